// File: bench/arith_opcode_decoder_asserts.sv
// Concurrent checks on the arithmetic decoder's result ports
module arith_opcode_decoder_checker (
  input wire logic       clk_sys_i,
  input wire logic       sys_rst_i,
  input wire logic       narrow_bus_i,
  input wire logic [7:0] q_byte_i,
  input wire logic       q_valid_i,
  input wire logic       q_ready_o,
  input wire logic       dec_valid_o,
  input wire logic [4:0] dec_kind_o,
  input wire logic [1:0] dec_seg_o,
  input wire logic       dec_word_o,
  input wire logic       dec_mem_o,
  input wire logic [1:0] dec_imm_bytes_o,
  input wire logic [6:0] dec_cyc_min_o,
  input wire logic [6:0] dec_cyc_max_o,
  input wire logic       dec_illegal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Narrow bus surcharge for word moves to or from memory; the decoder also adds it on the word accumulator borrow form
  wire [6:0] nx = (narrow_bus_i && dec_word_o && dec_mem_o) ? 7'h04 : 7'h00;
  wire       ar = dec_valid_o && dec_kind_o >= 5'h02 && dec_kind_o <= 5'h05;
  default clocking dc @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  AST_SEG: assert property (dec_valid_o && dec_kind_o == 5'h01 |->
    $past(q_valid_i) && $past(q_byte_i) == {3'h1, dec_seg_o, 3'h6} && dec_cyc_min_o == 7'h02)
    else $error("segment prefix decode or cost wrong");
  AST_ASCII: assert property (dec_valid_o && (dec_kind_o == 5'h07 || dec_kind_o == 5'h09) |->
    $past(q_byte_i) == (dec_kind_o == 5'h07 ? 8'h37 : 8'h3F)
    && dec_cyc_min_o == (dec_kind_o == 5'h07 ? 7'h08 : 7'h07))
    else $error("unpacked adjust decode or cost wrong");
  AST_DEC: assert property (dec_valid_o && (dec_kind_o == 5'h08 || dec_kind_o == 5'h0A) |->
    $past(q_byte_i) == (dec_kind_o == 5'h08 ? 8'h27 : 8'h2F) && dec_cyc_max_o == 7'h04)
    else $error("packed adjust decode or cost wrong");
  AST_RM: assert property (ar && dec_imm_bytes_o == 2'h0 |->
    dec_cyc_min_o == (dec_mem_o ? 7'h0A + nx : 7'h03) && dec_cyc_max_o == dec_cyc_min_o)
    else $error("register or memory form cost wrong");
  AST_IMM_MEM: assert property (ar && dec_imm_bytes_o != 2'h0 && dec_mem_o |->
    dec_cyc_min_o == 7'h10 + nx)
    else $error("immediate memory form cost wrong");
  AST_IMM_WIDTH: assert property (ar && dec_imm_bytes_o == 2'h2 |-> dec_word_o)
    else $error("two data bytes on a byte form");
  AST_SIGN_CHG: assert property (dec_valid_o && dec_kind_o == 5'h06 |->
    dec_cyc_min_o == (dec_mem_o ? 7'h0A + nx : 7'h03) && dec_imm_bytes_o == 2'h0)
    else $error("sign change cost wrong");
  AST_PRODUCT: assert property (dec_valid_o && dec_kind_o == 5'h0B |->
    dec_cyc_max_o == dec_cyc_min_o + 7'h02 && dec_cyc_min_o == (dec_mem_o
    ? (dec_word_o ? 7'h29 + nx : 7'h20) : (dec_word_o ? 7'h23 : 7'h1A)))
    else $error("multiply cost range wrong");
  AST_ILL: assert property (dec_valid_o && dec_illegal_o |->
    dec_kind_o == 5'h00 && dec_cyc_min_o == 7'h00 && dec_cyc_max_o == 7'h00)
    else $error("foreign byte reported with a kind or cost");
endmodule // arith_opcode_decoder_checker

bind arith_opcode_decoder arith_opcode_decoder_checker u_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .narrow_bus_i(narrow_bus_i),
  .q_byte_i(q_byte_i), .q_valid_i(q_valid_i), .q_ready_o(q_ready_o),
  .dec_valid_o(dec_valid_o), .dec_kind_o(dec_kind_o), .dec_seg_o(dec_seg_o),
  .dec_word_o(dec_word_o), .dec_mem_o(dec_mem_o), .dec_imm_bytes_o(dec_imm_bytes_o),
  .dec_cyc_min_o(dec_cyc_min_o), .dec_cyc_max_o(dec_cyc_max_o),
  .dec_illegal_o(dec_illegal_o)
);

// File: bench/prefetch_queue_model.sv
// Prefetch queue model offering opcode bytes to the decoder
module prefetch_queue_model (
  input  wire logic       clk_sys_i,
  output logic      [7:0] byte_o,
  output logic            valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    byte_o = 8'hA5;
    valid_o = 1'b0;
  end
  // Idle line toggles so a stale byte never passes for a fresh one
  task automatic stall();
    @(posedge clk_sys_i);
    valid_o <= 1'b0;
    byte_o  <= ~byte_o;
  endtask
  task automatic put(input logic [7:0] b, input int gap);
    repeat (gap) stall();
    @(posedge clk_sys_i);
    valid_o <= 1'b1;
    byte_o  <= b;
  endtask
endmodule // prefetch_queue_model

// File: bench/tb_arith_opcode_decoder.sv
// Self-checking bench for the arithmetic decoder
module tb_arith_opcode_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys_i = 1'b0;
  logic       sys_rst_i = 1'b1;
  logic       narrow_bus_i = 1'b0;
  wire  [7:0] q_byte_i;
  wire        q_valid_i, q_ready_o, dec_valid_o, dec_word_o, dec_mem_o, dec_illegal_o;
  wire  [4:0] dec_kind_o;
  wire  [1:0] dec_seg_o, dec_imm_bytes_o;
  wire  [6:0] dec_cyc_min_o, dec_cyc_max_o;
  int         n_errors = 0;
  int         checks = 0;
  int         cyc = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  prefetch_queue_model u_q (.clk_sys_i(clk_sys_i), .byte_o(q_byte_i), .valid_o(q_valid_i));
  arith_opcode_decoder u_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .narrow_bus_i(narrow_bus_i),
    .q_byte_i(q_byte_i), .q_valid_i(q_valid_i), .q_ready_o(q_ready_o),
    .dec_valid_o(dec_valid_o), .dec_kind_o(dec_kind_o), .dec_seg_o(dec_seg_o),
    .dec_word_o(dec_word_o), .dec_mem_o(dec_mem_o), .dec_imm_bytes_o(dec_imm_bytes_o),
    .dec_cyc_min_o(dec_cyc_min_o), .dec_cyc_max_o(dec_cyc_max_o),
    .dec_illegal_o(dec_illegal_o));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0d ns: seen %h expected %h", $time, got, exp);
    end
  endtask
  // Returns {modrm, illegal, kind, word, mem, imm bytes, min, max}
  function automatic logic [24:0] expect_f(input logic [7:0] op, m, input logic nb);
    logic [4:0] k;
    logic [6:0] lo, sp;
    logic [2:0] g;
    logic [1:0] ib;
    logic       mm, w;
    k = 5'h00; lo = 7'h00; sp = 7'h00; ib = 2'h0; g = 3'h0;
    casez (op)
      8'h26, 8'h2E, 8'h36, 8'h3E: {k, lo} = {5'h01, 7'h02};
      8'h37: {k, lo} = {5'h07, 7'h08};
      8'h27: {k, lo} = {5'h08, 7'h04};
      8'h3F: {k, lo} = {5'h09, 7'h07};
      8'h2F: {k, lo} = {5'h0A, 7'h04};
      8'b000000??: {k, g} = {5'h02, 3'h1};
      8'b000100??: {k, g} = {5'h03, 3'h1};
      8'b001010??: {k, g} = {5'h04, 3'h1};
      8'b000110??: {k, g} = {5'h05, 3'h1};
      8'b0000010?: {k, g} = {5'h02, 3'h2};
      8'b0001010?: {k, g} = {5'h03, 3'h2};
      8'b0010110?: {k, g} = {5'h04, 3'h2};
      8'b0001110?: {k, g} = {5'h05, 3'h2};
      8'b100000??: begin
        g = 3'h3;
        k = m[5:3] == 3'h0 ? 5'h02 : m[5:3] == 3'h2 ? 5'h03 : m[5:3] == 3'h5 ? 5'h04
          : m[5:3] == 3'h3 ? 5'h05 : 5'h00;
      end
      8'b1111011?: begin
        g = m[5:3] == 3'h4 ? 3'h4 : 3'h5;
        k = m[5:3] == 3'h3 ? 5'h06 : m[5:3] == 3'h4 ? 5'h0B : 5'h00;
      end
      default: k = 5'h00;
    endcase
    mm = m[7:6] != 2'h3;
    case (g)
      3'h1, 3'h5: lo = mm ? 7'h0A : 7'h03;
      3'h2: {lo, ib} = op[0] ? {7'h04, 2'h2} : {7'h03, 2'h1};
      3'h3: {lo, ib} = {mm ? 7'h10 : 7'h04, op[1:0] == 2'h1 ? 2'h2 : 2'h1};
      3'h4: {lo, sp} = {mm ? (op[0] ? 7'h29 : 7'h20) : (op[0] ? 7'h23 : 7'h1A), 7'h02};
      default: lo = lo;
    endcase
    // Foreign group fields still swallow their data bytes
    if (k == 5'h00) lo = 7'h00;
    mm = mm && g != 3'h0 && g != 3'h2 && k != 5'h00;
    w = op[0] && g != 3'h0 && k != 5'h00;
    if (nb && w && (mm || op[7:1] == 7'h0E)) lo = lo + 7'h04;
    return {g != 3'h0 && g != 3'h2, k == 5'h00, k, w, mm, ib, lo, lo + sp};
  endfunction
  task automatic run(input logic [7:0] op, m, input logic nb);
    logic [24:0] e;
    int          gap;
    e = expect_f(op, m, nb);
    gap = $urandom_range(0, 1);
    @(posedge clk_sys_i);
    narrow_bus_i <= nb;
    u_q.put(op, gap);
    if (e[24]) u_q.put(m, gap);
    repeat (e[15:14]) u_q.put(8'($urandom), gap);
    u_q.stall();
    #1;
    check({dec_valid_o, dec_illegal_o, dec_kind_o, e[23] ? 4'h0 : {dec_word_o, dec_mem_o,
      dec_imm_bytes_o}, dec_cyc_min_o, dec_cyc_max_o, e[22:18] == 5'h01 ? dec_seg_o : 2'h0},
      {1'b1, e[23:18], e[23] ? 4'h0 : e[17:14], e[13:0],
      e[22:18] == 5'h01 ? op[4:3] : 2'h0});
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] ops[$] = {8'h2E, 8'h36, 8'h3E, 8'h26, 8'h00, 8'h03, 8'h10, 8'h13, 8'h28,
      8'h2B, 8'h18, 8'h1B, 8'h04, 8'h05, 8'h14, 8'h15, 8'h2C, 8'h2D, 8'h1C, 8'h1D, 8'h80,
      8'h81, 8'h82, 8'h83, 8'hF6, 8'hF7, 8'h37, 8'h27, 8'h3F, 8'h2F, 8'h90};
    void'($urandom(54053));
    repeat (4) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    for (int p = 0; p < 4; p++)
      foreach (ops[i])
        for (int f = 0; f < 8; f++)
          run(ops[i], {p[0] ? 2'h3 : 2'h1, f[2:0], 3'h1}, p[1]);
    $display("directed sweep done");
    repeat (300) run(ops[$urandom_range(0, ops.size() - 1)], 8'($urandom), 1'($urandom));
    $display("random stream done");
    // Reset lands between opcode and operand-form byte
    u_q.put(8'h81, 0);
    u_q.stall();
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1;
    check({dec_valid_o, q_ready_o, dec_kind_o}, {1'b0, 1'b1, 5'h00});
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    run(8'h3E, 8'h00, 1'b0);
    $display("mid-run reset done");
    finish_test();
  end
endmodule // tb_arith_opcode_decoder

// File: src/arith_decode_defs.vh
// Opcode patterns, field positions and cycle costs for the arithmetic decoder
`ifndef ARITH_DECODE_DEFS_VH
`define ARITH_DECODE_DEFS_VH

`define OP_SEG_CODE      8'h2E
`define OP_SEG_STACK     8'h36
`define OP_SEG_DATA      8'h3E
`define OP_SEG_EXTRA     8'h26
`define OP_ASCII_ADD     8'h37
`define OP_DEC_ADD       8'h27
`define OP_ASCII_SUB     8'h3F
`define OP_DEC_SUB       8'h2F
`define OP_GRP3          7'h7B
`define OP_IMM_GRP       6'h20

// Top six opcode bits of register/memory forms
`define OPH_ADD          6'h00
`define OPH_ADC          6'h04
`define OPH_SUB          6'h0A
`define OPH_BORROW       6'h06
// Top seven opcode bits of accumulator immediate forms
`define OPA_ADD          7'h02
`define OPA_ADC          7'h0A
`define OPA_SUB          7'h16
`define OPA_BORROW       7'h0E

// Operation field values
`define FLD_ADD          3'h0
`define FLD_ADC          3'h2
`define FLD_BORROW       3'h3
`define FLD_SUB          3'h5
`define FLD_SIGN_CHG     3'h3
`define FLD_PRODUCT      3'h4
`define MOD_REG          2'h3

// Operation codes reported
`define K_NONE           5'h00
`define K_SEG            5'h01
`define K_ADD            5'h02
`define K_ADC            5'h03
`define K_SUB            5'h04
`define K_BORROW         5'h05
`define K_SIGN_CHG       5'h06
`define K_ASCII_SUM      5'h07
`define K_DEC_SUM        5'h08
`define K_ASCII_DIFF     5'h09
`define K_DEC_DIFF       5'h0A
`define K_PRODUCT        5'h0B

// Cycle costs
`define CY_SEG           7'h02
`define CY_RM_REG        7'h03
`define CY_RM_MEM        7'h0A
`define CY_ACC_B         7'h03
`define CY_ACC_W         7'h04
`define CY_IMM_REG       7'h04
`define CY_IMM_MEM       7'h10
`define CY_ASCII_SUM     7'h08
`define CY_DEC_SUM       7'h04
`define CY_ASCII_DIFF    7'h07
`define CY_DEC_DIFF      7'h04
`define CY_PROD_RB_MIN   7'h1A
`define CY_PROD_RW_MIN   7'h23
`define CY_PROD_MB_MIN   7'h20
`define CY_PROD_MW_MIN   7'h29
`define CY_PROD_SPAN     7'h02
`define CY_NARROW_EXTRA  7'h04

`endif

// File: src/arith_opcode_decoder.v
// Arithmetic and segment-prefix decoder fed from the prefetch queue
`include "arith_decode_defs.vh"
module arith_opcode_decoder (
  // Clock and reset
  input  wire       clk_sys_i,
  input  wire       sys_rst_i,
  // Configuration
  input  wire       narrow_bus_i,
  // Queue byte stream
  input  wire [7:0] q_byte_i,
  input  wire       q_valid_i,
  output wire       q_ready_o,
  // Decode result
  output reg        dec_valid_o,
  output reg  [4:0] dec_kind_o,
  output reg  [1:0] dec_seg_o,
  output reg        dec_word_o,
  output reg        dec_mem_o,
  output reg  [1:0] dec_imm_bytes_o,
  output reg  [6:0] dec_cyc_min_o,
  output reg  [6:0] dec_cyc_max_o,
  output reg        dec_illegal_o
);
  localparam [1:0] ST_OPCODE = 2'd0;
  localparam [1:0] ST_MODRM  = 2'd1;
  localparam [1:0] ST_IMM    = 2'd2;

  reg  [1:0] state_q;
  reg  [7:0] op_q;
  reg  [7:0] modrm_q;
  reg  [1:0] imm_left_q;
  reg  [1:0] imm_total_q;

  wire [4:0] c_kind;
  wire       c_modrm;
  wire       c_acc;
  wire       c_imm;
  wire       c_grp3;
  wire [1:0] c_seg;

  // Classification of the byte held as opcode
  wire [7:0] cls_byte = (state_q == ST_OPCODE) ? q_byte_i : op_q;

  opcode_classify u_cls (
    .op_i          (cls_byte),
    .kind_o        (c_kind),
    .needs_modrm_o (c_modrm),
    .acc_imm_o     (c_acc),
    .imm_grp_o     (c_imm),
    .grp3_o        (c_grp3),
    .seg_o         (c_seg)
  );

  // Resolve final kind using the operation field
  reg [4:0] fin_kind;
  reg       fin_mem;
  reg [7:0] mrm;
  always @* begin
    mrm      = (state_q == ST_MODRM) ? q_byte_i : modrm_q;
    fin_kind = c_kind;
    fin_mem  = c_modrm && (mrm[7:6] != `MOD_REG);
    if (c_imm) begin
      case (mrm[5:3])
        `FLD_ADD: fin_kind = `K_ADD;
        `FLD_ADC: fin_kind = `K_ADC;
        `FLD_BORROW: fin_kind = `K_BORROW;
        `FLD_SUB: fin_kind = `K_SUB;
        default:  fin_kind = `K_NONE;
      endcase
    end else if (c_grp3) begin
      case (mrm[5:3])
        `FLD_SIGN_CHG: fin_kind = `K_SIGN_CHG;
        `FLD_PRODUCT:  fin_kind = `K_PRODUCT;
        default:  fin_kind = `K_NONE;
      endcase
    end
  end

  wire [6:0] cost_min;
  wire [6:0] cost_max;

  cycle_cost u_cost (
    .kind_i       (fin_kind),
    .mem_i        (fin_mem),
    .word_i       (cls_byte[0]),
    .acc_imm_i    (c_acc),
    .imm_grp_i    (c_imm),
    .narrow_bus_i (narrow_bus_i),
    .min_o        (cost_min),
    .max_o        (cost_max)
  );

  // Immediate byte count for the current form
  reg [1:0] imm_cnt;
  always @* begin
    imm_cnt = 2'd0;
    if (c_acc)
      imm_cnt = cls_byte[0] ? 2'd2 : 2'd1;
    else if (c_imm)
      imm_cnt = (cls_byte[1:0] == 2'b01) ? 2'd2 : 2'd1;
  end

  // Always drains the queue; decode never stalls
  assign q_ready_o = 1'b1;
  wire take = q_valid_i;

  reg fire;
  always @* begin
    fire = 1'b0;
    case (state_q)
      ST_OPCODE: fire = take && !c_modrm && (imm_cnt == 2'd0);
      ST_MODRM:  fire = take && (imm_cnt == 2'd0);
      ST_IMM:    fire = take && (imm_left_q == 2'd1);
      default:   fire = 1'b0;
    endcase
  end

  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q     <= ST_OPCODE;
      op_q        <= 8'h00;
      modrm_q     <= 8'h00;
      imm_left_q  <= 2'd0;
      imm_total_q <= 2'd0;
    end else if (take) begin
      case (state_q)
        ST_OPCODE: begin
          op_q        <= q_byte_i;
          modrm_q     <= 8'h00;
          imm_total_q <= imm_cnt;
          imm_left_q  <= imm_cnt;
          if (c_modrm)
            state_q <= ST_MODRM;
          else if (imm_cnt != 2'd0)
            state_q <= ST_IMM;
        end
        ST_MODRM: begin
          modrm_q     <= q_byte_i;
          imm_total_q <= imm_cnt;
          imm_left_q  <= imm_cnt;
          state_q     <= (imm_cnt != 2'd0) ? ST_IMM : ST_OPCODE;
        end
        ST_IMM: begin
          imm_left_q <= imm_left_q - 2'd1;
          if (imm_left_q == 2'd1)
            state_q <= ST_OPCODE;
        end
        default: state_q <= ST_OPCODE;
      endcase
    end
  end

  // Result registers, updated on the last byte of each instruction
  always @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      dec_valid_o     <= 1'b0;
      dec_kind_o      <= `K_NONE;
      dec_seg_o       <= 2'h0;
      dec_word_o      <= 1'b0;
      dec_mem_o       <= 1'b0;
      dec_imm_bytes_o <= 2'd0;
      dec_cyc_min_o   <= 7'h00;
      dec_cyc_max_o   <= 7'h00;
      dec_illegal_o   <= 1'b0;
    end else begin
      dec_valid_o <= fire;
      if (fire) begin
        dec_kind_o      <= fin_kind;
        dec_seg_o       <= c_seg;
        dec_word_o      <= cls_byte[0] && (fin_kind != `K_SEG) && !(c_kind >= `K_ASCII_SUM
                           && c_kind <= `K_DEC_DIFF);
        dec_mem_o       <= fin_mem;
        dec_imm_bytes_o <= (state_q == ST_IMM) ? imm_total_q : 2'd0;
        dec_cyc_min_o   <= cost_min;
        dec_cyc_max_o   <= cost_max;
        // Bytes outside this group are flagged for other decoders
        dec_illegal_o   <= (fin_kind == `K_NONE);
      end
    end
  end
endmodule // arith_opcode_decoder

// File: src/cycle_cost.v
// Cycle cost table for a decoded arithmetic instruction
`include "arith_decode_defs.vh"
module cycle_cost (
  // Decoded form
  input  wire [4:0] kind_i,
  input  wire       mem_i,
  input  wire       word_i,
  input  wire       acc_imm_i,
  input  wire       imm_grp_i,
  input  wire       narrow_bus_i,
  // Cost
  output reg  [6:0] min_o,
  output reg  [6:0] max_o
);
  reg [6:0] base;
  reg       starred;
  always @* begin
    base    = 7'h00;
    starred = 1'b0;
    max_o   = 7'h00;
    case (kind_i)
      `K_SEG:  base = `CY_SEG;
      `K_ASCII_SUM:  base = `CY_ASCII_SUM;
      `K_DEC_SUM:    base = `CY_DEC_SUM;
      `K_ASCII_DIFF: base = `CY_ASCII_DIFF;
      `K_DEC_DIFF:   base = `CY_DEC_DIFF;
      `K_PRODUCT: begin
        starred = 1'b1;
        case ({mem_i, word_i})
          2'b00:   base = `CY_PROD_RB_MIN;
          2'b01:   base = `CY_PROD_RW_MIN;
          2'b10:   base = `CY_PROD_MB_MIN;
          default: base = `CY_PROD_MW_MIN;
        endcase
      end
      `K_ADD, `K_ADC, `K_SUB, `K_BORROW, `K_SIGN_CHG: begin
        if (acc_imm_i) begin
          base = word_i ? `CY_ACC_W : `CY_ACC_B;
          starred = (kind_i == `K_BORROW);
        end else begin
          starred = 1'b1;
          if (imm_grp_i)
            base = mem_i ? `CY_IMM_MEM : `CY_IMM_REG;
          else
            base = mem_i ? `CY_RM_MEM : `CY_RM_REG;
        end
      end
      default: base = 7'h00;
    endcase
    if (narrow_bus_i && starred && word_i && (mem_i || acc_imm_i))
      base = base + `CY_NARROW_EXTRA;
    min_o = base;
    max_o = (kind_i == `K_PRODUCT) ? base + `CY_PROD_SPAN : base;
  end
endmodule // cycle_cost

// File: src/opcode_classify.v
// First-byte classifier: maps an opcode byte onto its instruction family
`include "arith_decode_defs.vh"
module opcode_classify (
  // Opcode
  input  wire [7:0] op_i,
  // Family
  output reg  [4:0] kind_o,
  output reg        needs_modrm_o,
  output reg        acc_imm_o,
  output reg        imm_grp_o,
  output reg        grp3_o,
  output reg  [1:0] seg_o
);
  always @* begin
    kind_o        = `K_NONE;
    needs_modrm_o = 1'b0;
    acc_imm_o     = 1'b0;
    imm_grp_o     = 1'b0;
    grp3_o        = 1'b0;
    seg_o         = 2'h0;
    if (op_i == `OP_SEG_CODE || op_i == `OP_SEG_STACK ||
        op_i == `OP_SEG_DATA || op_i == `OP_SEG_EXTRA) begin
      kind_o = `K_SEG;
      seg_o  = op_i[4:3];
    end else if (op_i == `OP_ASCII_ADD) begin
      kind_o = `K_ASCII_SUM;
    end else if (op_i == `OP_DEC_ADD) begin
      kind_o = `K_DEC_SUM;
    end else if (op_i == `OP_ASCII_SUB) begin
      kind_o = `K_ASCII_DIFF;
    end else if (op_i == `OP_DEC_SUB) begin
      kind_o = `K_DEC_DIFF;
    end else if (op_i[7:2] == `OPH_ADD || op_i[7:2] == `OPH_ADC ||
                 op_i[7:2] == `OPH_SUB || op_i[7:2] == `OPH_BORROW) begin
      needs_modrm_o = 1'b1;
      case (op_i[7:2])
        `OPH_ADD: kind_o = `K_ADD;
        `OPH_ADC: kind_o = `K_ADC;
        `OPH_SUB: kind_o = `K_SUB;
        default:  kind_o = `K_BORROW;
      endcase
    end else if (op_i[7:1] == `OPA_ADD || op_i[7:1] == `OPA_ADC ||
                 op_i[7:1] == `OPA_SUB || op_i[7:1] == `OPA_BORROW) begin
      acc_imm_o = 1'b1;
      case (op_i[7:1])
        `OPA_ADD: kind_o = `K_ADD;
        `OPA_ADC: kind_o = `K_ADC;
        `OPA_SUB: kind_o = `K_SUB;
        default:  kind_o = `K_BORROW;
      endcase
    end else if (op_i[7:2] == `OP_IMM_GRP) begin
      needs_modrm_o = 1'b1;
      imm_grp_o     = 1'b1;
    end else if (op_i[7:1] == `OP_GRP3) begin
      needs_modrm_o = 1'b1;
      grp3_o        = 1'b1;
    end
  end
endmodule // opcode_classify
